// >>> mtseq_delay.sv
`timescale 1ns/1ns
`include "mtseq_regs.svh"
module mtseq_delay #(
  parameter int W = 37
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] ticks,
  // Status
  output logic              busy,
  output logic              expired
);
  logic [W-1:0] count;

  // Down-counter loaded per sample
  always_ff @(posedge clk) begin
    if (srst) begin
      count   <= '0;
      busy    <= 1'b0;
      expired <= 1'b0;
    end else if (load) begin
      count   <= ticks;
      busy    <= 1'b1;
      expired <= 1'b0;
    end else if (busy && count == '0) begin
      busy    <= 1'b0;
      expired <= 1'b1;
    end else begin
      expired <= 1'b0;
      if (busy) begin
        count <= count - W'(1);
      end
    end
  end
endmodule // mtseq_delay

// >>> mtseq_engine_model.sv
`timescale 1ns/1ns
module mtseq_engine_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Engine handshake
  input  wire logic reading_start,
  input  wire logic slow,
  output logic      reading_done
);
  int cnt;
  // One reading at a time, prompt or slow
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt          <= 0;
      reading_done <= 1'b0;
    end else begin
      reading_done <= (cnt == 1);
      if (cnt > 0) cnt <= cnt - 1;
      else if (reading_start) cnt <= slow ? 30 : 3;
    end
  end
endmodule // mtseq_engine_model

// >>> mtseq_pkg.sv
package mtseq_pkg;
  typedef enum logic [1:0] {
    MTSEQ_SRC_IMM = 2'h0,
    MTSEQ_SRC_BUS = 2'h1,
    MTSEQ_SRC_EXT = 2'h2,
    MTSEQ_SRC_AUTO = 2'h3
  } mtseq_src_t;
  typedef enum logic [2:0] {
    MTSEQ_IDLE  = 3'h0,
    MTSEQ_SETUP = 3'h1,
    MTSEQ_WAIT  = 3'h3,
    MTSEQ_DELAY = 3'h2,
    MTSEQ_READ  = 3'h6
  } mtseq_state_t;
endpackage

// >>> mtseq_properties.sv
`timescale 1ns/1ns
module mtseq_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Sequencer
  input wire logic        reading_done,
  input wire logic        reading_start,
  input wire logic        sample_active,
  input wire logic        trig_waiting,
  input wire logic        measurement_complete_output
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  sequence done_low_s;
    ##[1:6] !measurement_complete_output;
  endsequence
  sequence low_rest_s;
    !measurement_complete_output [*4] ##1 measurement_complete_output;
  endsequence
  ////////////////////////////////////////
  start_one_cycle_a: assert property (reading_start |=> !reading_start)
    else $error("start pulse longer than one cycle");
  start_in_sample_a: assert property (reading_start |-> sample_active)
    else $error("reading started outside a measurement");
  delay_first_a: assert property ($rose(sample_active) |-> !reading_start)
    else $error("reading started with no delay");
  wait_not_busy_a: assert property (trig_waiting |-> !sample_active)
    else $error("waiting while measuring");
  done_pulse_a: assert property (reading_done && sample_active |-> done_low_s)
    else $error("no complete pulse after reading");
  done_width_a: assert property ($fell(measurement_complete_output) |-> low_rest_s)
    else $error("complete pulse width wrong");
  bus_answer_a: assert property (psel && penable |-> pready && !pslverr)
    else $error("bus answer wrong");
  read_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed outside read");
endmodule // mtseq_properties

// >>> mtseq_pulse.sv
`timescale 1ns/1ns
module mtseq_pulse #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Pulse input and width
  input  wire logic         fire,
  input  wire logic [W-1:0] width,
  // Low-true output
  output logic              out_n
);
  logic [W-1:0] left;

  always_ff @(posedge clk) begin
    if (srst) begin
      left  <= '0;
      out_n <= 1'b1;
    end else if (fire) begin
      left  <= width;
      out_n <= 1'b0;
    end else if (left > W'(1)) begin
      left  <= left - W'(1);
    end else begin
      left  <= '0;
      out_n <= 1'b1;
    end
  end
endmodule // mtseq_pulse

// >>> mtseq_regs.svh
`ifndef MTSEQ_REGS_SVH
`define MTSEQ_REGS_SVH
// Register byte offsets
`define MTSEQ_OFF_CTRL     12'h000
`define MTSEQ_OFF_SRC      12'h004
`define MTSEQ_OFF_SAMPLES  12'h008
`define MTSEQ_OFF_TRIGS    12'h00c
`define MTSEQ_OFF_DELAY    12'h010
`define MTSEQ_OFF_STATUS   12'h014
`define MTSEQ_OFF_CMD      12'h018
`define MTSEQ_OFF_MEASURE  12'h01c
// Command register bits
`define MTSEQ_CMD_INIT     0
`define MTSEQ_CMD_CONF     1
`define MTSEQ_CMD_MEAS     2
`define MTSEQ_CMD_TRG      3
`define MTSEQ_CMD_CLEAR    4
`define MTSEQ_CMD_RESET    5
// Control register bits
`define MTSEQ_CTRL_REMOTE  0
`define MTSEQ_CTRL_KEYMODE 1
`define MTSEQ_CTRL_DLYAUTO 2
// Limits and reset values
`define MTSEQ_COUNT_MAX    16'd50000
`define MTSEQ_COUNT_ONE    16'd1
`define MTSEQ_DELAY_MAX_S  32'd3600
// Timing
`define MTSEQ_CLK_HZ       32'd20000000
`define MTSEQ_SETUP_MS     32'd20
`define MTSEQ_SETUP_CYC    ((`MTSEQ_CLK_HZ / 32'd1000) * `MTSEQ_SETUP_MS)
`define MTSEQ_DELAY_MAX_C  (64'd20000000 * 64'd3600)
`endif

// >>> mtseq_top.sv
`timescale 1ns/1ns
`include "mtseq_regs.svh"
module mtseq_top #(
  parameter int unsigned SETUP_CYC = `MTSEQ_SETUP_CYC,
  parameter int          DW        = 37,
  parameter logic [36:0] AUTO_DLY  = 37'h0000000014,
  parameter logic [3:0]  DONE_W    = 4'h4
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Front panel, link and measurement engine
  input  wire logic        single_key,
  input  wire logic        group_exec_trig,
  input  wire logic        ext_trig_n,
  input  wire logic        reading_done,
  // Measurement engine and indicators
  output logic             reading_start,
  output logic             sample_active,
  output logic             trig_waiting,
  output logic             measurement_complete_output
);
  import mtseq_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  mtseq_state_t state;
  mtseq_src_t   src;
  logic         remote;
  logic         dly_auto;
  logic [31:0]  dly_ticks_reg;
  logic [15:0]  samples;
  logic [15:0]  trigs;
  logic         trigs_inf;
  logic [15:0]  sample_cnt;
  logic [15:0]  trig_cnt;
  logic [31:0]  setup_cnt;
  logic         ext_latch;
  logic         ext_q;
  logic         trig_ignored;
  logic [31:0]  meas_total;

  wire wr = psel && penable && pwrite;
  wire [5:0] cmd = (wr && paddr == `MTSEQ_OFF_CMD) ? pwdata[5:0] : 6'h00;
  wire do_reset  = cmd[`MTSEQ_CMD_RESET];
  wire do_conf   = cmd[`MTSEQ_CMD_CONF] || cmd[`MTSEQ_CMD_MEAS];
  wire do_init   = cmd[`MTSEQ_CMD_INIT] || cmd[`MTSEQ_CMD_MEAS];
  wire do_clear  = cmd[`MTSEQ_CMD_CLEAR];
  wire ext_fall  = ext_q && !ext_trig_n;

  ////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  function automatic logic [15:0] clamp_cnt(input logic [31:0] v);
    if (v == 32'h0) begin
      return `MTSEQ_COUNT_ONE;
    end else if (v > 32'(`MTSEQ_COUNT_MAX)) begin
      return `MTSEQ_COUNT_MAX;
    end else begin
      return v[15:0];
    end
  endfunction

  // Interface reset keeps local or remote control
  always_ff @(posedge clk) begin
    if (srst) begin
      remote <= 1'b0;
    end else if (wr && paddr == `MTSEQ_OFF_CTRL) begin
      remote <= pwdata[`MTSEQ_CTRL_REMOTE];
    end
  end

  // Trigger source
  always_ff @(posedge clk) begin
    if (srst) begin
      src <= MTSEQ_SRC_AUTO;
    end else if (do_reset) begin
      src <= remote ? MTSEQ_SRC_IMM : MTSEQ_SRC_AUTO;
    end else if (do_conf) begin
      src <= MTSEQ_SRC_IMM;
    end else if (wr && paddr == `MTSEQ_OFF_CTRL) begin
      if (pwdata[`MTSEQ_CTRL_REMOTE] && !remote) begin
        src <= MTSEQ_SRC_IMM;
      end else if (!pwdata[`MTSEQ_CTRL_REMOTE] && pwdata[`MTSEQ_CTRL_KEYMODE]) begin
        src <= MTSEQ_SRC_EXT;
      end else if (!pwdata[`MTSEQ_CTRL_REMOTE]) begin
        src <= MTSEQ_SRC_AUTO;
      end
    end else if (wr && paddr == `MTSEQ_OFF_SRC && remote && pwdata[1:0] != 2'h3) begin
      src <= mtseq_src_t'(pwdata[1:0]);
    end
  end

  // Counts and delay configuration
  always_ff @(posedge clk) begin
    if (srst || do_reset || do_conf) begin
      samples   <= `MTSEQ_COUNT_ONE;
      trigs     <= `MTSEQ_COUNT_ONE;
      trigs_inf <= 1'b0;
      dly_auto  <= 1'b1;
      dly_ticks_reg <= 32'h0;
    end else if (wr) begin
      case (paddr)
        `MTSEQ_OFF_SAMPLES: samples <= clamp_cnt(pwdata);
        `MTSEQ_OFF_TRIGS: begin
          trigs     <= clamp_cnt({1'b0, pwdata[30:0]});
          trigs_inf <= pwdata[31];
        end
        `MTSEQ_OFF_DELAY: dly_ticks_reg <= pwdata;
        `MTSEQ_OFF_CTRL: dly_auto <= pwdata[`MTSEQ_CTRL_DLYAUTO];
        default: ;
      endcase
    end
  end

  // Delay in ticks; software gives milliseconds, clipped to the top
  logic [DW-1:0] dly_ticks;
  always_comb begin
    logic [63:0] t;
    t = 64'(dly_ticks_reg) * (64'(`MTSEQ_CLK_HZ) / 64'd1000);
    if (t > `MTSEQ_DELAY_MAX_C) begin
      t = `MTSEQ_DELAY_MAX_C;
    end
    dly_ticks = dly_auto ? AUTO_DLY : t[DW-1:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Trigger qualification
  logic key_ok, bus_trg, ext_trg, trig_now, dly_load, dly_exp, last_trig;

  always_ff @(posedge clk) begin
    if (srst) begin
      ext_q <= 1'b1;
    end else begin
      ext_q <= ext_trig_n;
    end
  end

  assign key_ok  = single_key && !remote;
  assign bus_trg = cmd[`MTSEQ_CMD_TRG] || group_exec_trig;
  assign ext_trg = ext_fall || ext_latch;

  always_comb begin
    trig_now = 1'b0;
    if (state == MTSEQ_WAIT) begin
      case (src)
        MTSEQ_SRC_IMM:  trig_now = 1'b1;
        MTSEQ_SRC_AUTO: trig_now = !remote;
        MTSEQ_SRC_BUS:  trig_now = bus_trg;
        MTSEQ_SRC_EXT:  trig_now = ext_trg || key_ok;
        default:        trig_now = 1'b0;
      endcase
    end
  end

  // One buffered external pulse
  always_ff @(posedge clk) begin
    if (srst || do_clear) begin
      ext_latch <= 1'b0;
    end else if (ext_fall && src == MTSEQ_SRC_EXT && state != MTSEQ_WAIT
                 && state != MTSEQ_IDLE && state != MTSEQ_SETUP) begin
      ext_latch <= 1'b1;
    end else if (trig_now) begin
      ext_latch <= 1'b0;
    end
  end

  // Bus or key triggers outside the wait state set the sticky ignored flag
  always_ff @(posedge clk) begin
    if (srst || do_reset) begin
      trig_ignored <= 1'b0;
    end else if ((bus_trg || key_ok) && state != MTSEQ_WAIT) begin
      trig_ignored <= 1'b1;
    end else if (wr && paddr == `MTSEQ_OFF_STATUS) begin
      trig_ignored <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  assign last_trig = !trigs_inf && (!remote || trig_cnt >= trigs);

  always_ff @(posedge clk) begin
    if (srst || do_clear || do_reset) begin
      state <= MTSEQ_IDLE;
      sample_cnt <= 16'h0;
      trig_cnt   <= 16'h0;
      setup_cnt  <= 32'h0;
    end else begin
      case (state)
        MTSEQ_IDLE: begin
          trig_cnt <= 16'h0;
          if (!remote) begin
            state <= MTSEQ_WAIT;
          end else if (do_init) begin
            state     <= MTSEQ_SETUP;
            setup_cnt <= SETUP_CYC;
          end
        end
        MTSEQ_SETUP: begin
          if (setup_cnt <= 32'h1) begin
            state <= MTSEQ_WAIT;
          end else begin
            setup_cnt <= setup_cnt - 32'h1;
          end
        end
        MTSEQ_WAIT: begin
          if (trig_now) begin
            state      <= MTSEQ_DELAY;
            sample_cnt <= 16'h1;
            trig_cnt   <= trig_cnt + 16'h1;
          end
        end
        MTSEQ_DELAY: begin
          if (dly_exp) begin
            state <= MTSEQ_READ;
          end
        end
        MTSEQ_READ: begin
          if (reading_done) begin
            if (sample_cnt < samples) begin
              state      <= MTSEQ_DELAY;
              sample_cnt <= sample_cnt + 16'h1;
            end else if (!remote || !last_trig) begin
              state <= MTSEQ_WAIT;
            end else begin
              state <= MTSEQ_IDLE;
            end
          end
        end
        default: state <= MTSEQ_IDLE;
      endcase
    end
  end

  assign dly_load = (state == MTSEQ_WAIT && trig_now)
                 || (state == MTSEQ_READ && reading_done && sample_cnt < samples);

  mtseq_delay #(
    .W (DW)
  ) u_delay (
    .clk     (clk),
    .srst    (srst || do_clear),
    .load    (dly_load),
    .ticks   (dly_ticks),
    .busy    (),
    .expired (dly_exp)
  );

  // Reading start and completion count
  always_ff @(posedge clk) begin
    if (srst) begin
      reading_start <= 1'b0;
      meas_total    <= 32'h0;
    end else begin
      reading_start <= dly_exp && state == MTSEQ_DELAY && !do_clear;
      if (state == MTSEQ_READ && reading_done) begin
        meas_total <= meas_total + 32'h1;
      end
    end
  end

  mtseq_pulse #(
    .W (4)
  ) u_done (
    .clk   (clk),
    .srst  (srst),
    // A reading that ends on an abort edge still completed
    .fire  (state == MTSEQ_READ && reading_done),
    .width (DONE_W),
    .out_n (measurement_complete_output)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      sample_active <= 1'b0;
      trig_waiting  <= 1'b0;
    end else begin
      // Aborted sequences drop the activity flag at once
      sample_active <= !(do_clear || do_reset)
                    && (state == MTSEQ_DELAY || state == MTSEQ_READ);
      trig_waiting  <= state == MTSEQ_WAIT && src != MTSEQ_SRC_AUTO
                    && src != MTSEQ_SRC_IMM;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `MTSEQ_OFF_CTRL:    prdata <= {29'h0, dly_auto, src == MTSEQ_SRC_EXT, remote};
        `MTSEQ_OFF_SRC:     prdata <= {30'h0, src};
        `MTSEQ_OFF_SAMPLES: prdata <= {16'h0, samples};
        `MTSEQ_OFF_TRIGS:   prdata <= {trigs_inf, 15'h0, trigs};
        `MTSEQ_OFF_DELAY:   prdata <= dly_ticks_reg;
        `MTSEQ_OFF_STATUS:  prdata <= {24'h0, ext_latch, trig_ignored, 3'h0, state};
        `MTSEQ_OFF_MEASURE: prdata <= meas_total;
        default:            prdata <= 32'h0;
      endcase
    end
  end
endmodule // mtseq_top

// >>> tb_measurement_trigger_sequencer.sv
`timescale 1ns/1ns
`include "mtseq_regs.svh"
module tb_measurement_trigger_sequencer;
  import mtseq_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, reading_done, reading_start, sample_active;
  logic        trig_waiting, measurement_complete_output;
  logic        single_key = 1'b0, group_exec_trig = 1'b0, ext_trig_n = 1'b1, slow = 1'b0;
  int          miscompares = 0, n_tests = 0, starts = 0, base, i, n;
  integer      seed = 32'hc702a93c;
  logic        mc_q = 1'b1;
  int          pulses = 0, pbase, mbase;
  always #25 clk = ~clk;
  mtseq_top #(.SETUP_CYC(10)) dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .single_key(single_key), .group_exec_trig(group_exec_trig),
    .ext_trig_n(ext_trig_n), .reading_done(reading_done), .reading_start(reading_start),
    .sample_active(sample_active), .trig_waiting(trig_waiting),
    .measurement_complete_output(measurement_complete_output));
  mtseq_engine_model u_eng (.clk(clk), .srst(srst), .reading_start(reading_start),
    .slow(slow), .reading_done(reading_done));
  always @(posedge clk) if (reading_start === 1'b1) starts <= starts + 1;
  // Counts low-true completion pulses
  always @(posedge clk) begin
    mc_q <= measurement_complete_output;
    if (mc_q === 1'b1 && measurement_complete_output === 1'b0) pulses <= pulses + 1;
  end
  ////////////////////////////////////////
  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task ticks(input int c);
    repeat (c) @(posedge clk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 16) begin
      miscompares++;
      end_of_test;
    end else begin
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    check(rd, exp, what);
  endtask
  task wait_idle;
    int k;
    for (k = 0; k < 2000; k++) begin
      apb(1'b0, `MTSEQ_OFF_STATUS, 32'h0);
      if (rd[2:0] === 3'h0) break;
    end
    check(32'(k < 2000), 32'h1, "idle reached");
    if (k == 2000) end_of_test;
  endtask
  task wait_armed;
    int k;
    ticks(5);
    for (k = 0; k < 300 && trig_waiting !== 1'b1; k++) @(posedge clk);
    check(32'(trig_waiting), 32'h1, "armed again");
  endtask
  task ext_pulse;
    @(posedge clk) ext_trig_n <= 1'b0;
    ticks(2);
    ext_trig_n <= 1'b1;
  endtask
  ////////////////////////////////////////
  initial begin
    ticks(4);
    srst <= 1'b0;
    rdchk(`MTSEQ_OFF_SRC, 32'h3, "src reset");
    apb(1'b0, `MTSEQ_OFF_CTRL, 32'h0);
    check(rd & 32'h5, 32'h4, "ctrl reset");
    rdchk(`MTSEQ_OFF_SAMPLES, 32'h1, "samples reset");
    rdchk(`MTSEQ_OFF_TRIGS, 32'h1, "trigs reset");
    rdchk(12'h040, 32'h0, "unmapped");
    base = starts;
    ticks(200);
    check(32'(starts > base), 32'h1, "auto readings");
    $display("test reset_auto done");
    apb(1'b1, `MTSEQ_OFF_CTRL, 32'h5);
    rdchk(`MTSEQ_OFF_SRC, 32'h0, "src remote");
    apb(1'b1, `MTSEQ_OFF_CMD, 32'h10);
    ticks(40);
    apb(1'b0, `MTSEQ_OFF_STATUS, 32'h0);
    check(32'(rd[2:0]), 32'h0, "clear idle");
    n = 2 + ($unsigned($random(seed)) % 4);
    apb(1'b1, `MTSEQ_OFF_SAMPLES, n);
    apb(1'b1, `MTSEQ_OFF_TRIGS, 32'h3);
    apb(1'b0, `MTSEQ_OFF_MEASURE, 32'h0);
    mbase = rd;
    pbase = pulses;
    base = starts;
    apb(1'b1, `MTSEQ_OFF_CMD, 32'h1);
    wait_idle;
    check(starts - base, n * 3, "imm bursts");
    check(pulses - pbase, n * 3, "complete pulses");
    rdchk(`MTSEQ_OFF_MEASURE, mbase + n * 3, "measure count");
    $display("test immediate done");
    apb(1'b1, `MTSEQ_OFF_SAMPLES, 32'h2);
    apb(1'b1, `MTSEQ_OFF_TRIGS, 32'h1);
    apb(1'b1, `MTSEQ_OFF_SRC, 32'h1);
    base = starts;
    apb(1'b1, `MTSEQ_OFF_CMD, 32'h1);
    apb(1'b1, `MTSEQ_OFF_CMD, 32'h8);
    ticks(20);
    check(32'(trig_waiting), 32'h1, "bus waiting");
    @(posedge clk) single_key <= 1'b1;
    @(posedge clk) single_key <= 1'b0;
    ticks(5);
    check(starts - base, 0, "early and key");
    @(posedge clk) group_exec_trig <= 1'b1;
    @(posedge clk) group_exec_trig <= 1'b0;
    wait_idle;
    check(starts - base, 2, "get burst");
    apb(1'b1, `MTSEQ_OFF_CMD, 32'h8);
    ticks(20);
    check(starts - base, 2, "trg in idle");
    $display("test bus done");
    slow <= 1'b1;
    apb(1'b1, `MTSEQ_OFF_TRIGS, 32'h2);
    apb(1'b1, `MTSEQ_OFF_SAMPLES, 32'h1);
    apb(1'b1, `MTSEQ_OFF_SRC, 32'h2);
    apb(1'b1, `MTSEQ_OFF_STATUS, 32'h40);
    base = starts;
    apb(1'b1, `MTSEQ_OFF_CMD, 32'h1);
    ticks(20);
    ext_pulse;
    ticks(8);
    ext_pulse;
    wait_idle;
    check(starts - base, 2, "ext latched");
    apb(1'b0, `MTSEQ_OFF_STATUS, 32'h0);
    check(32'(rd[6]), 32'h0, "no ignored flag");
    slow <= 1'b0;
    $display("test external done");
    apb(1'b1, `MTSEQ_OFF_SAMPLES, 32'd60000);
    rdchk(`MTSEQ_OFF_SAMPLES, 32'd50000, "samples clamp");
    apb(1'b1, `MTSEQ_OFF_CMD, 32'h1);
    ticks(100);
    apb(1'b1, `MTSEQ_OFF_CMD, 32'h10);
    ticks(2);
    apb(1'b0, `MTSEQ_OFF_STATUS, 32'h0);
    check(32'(rd[2:0]), 32'h0, "abort idle");
    rdchk(`MTSEQ_OFF_SAMPLES, 32'd50000, "samples kept");
    rdchk(`MTSEQ_OFF_SRC, 32'h2, "src kept");
    rdchk(`MTSEQ_OFF_TRIGS, 32'h2, "trigs kept");
    ticks(40);
    $display("test clear done");
    for (i = 1; i < 3; i++) begin
      apb(1'b1, `MTSEQ_OFF_SRC, 32'h1);
      apb(1'b1, `MTSEQ_OFF_SAMPLES, 32'h7);
      apb(1'b1, `MTSEQ_OFF_TRIGS, 32'h4);
      apb(1'b1, `MTSEQ_OFF_CTRL, 32'h1);
      base = starts;
      apb(1'b1, `MTSEQ_OFF_CMD, 32'h1 << i);
      wait_idle;
      rdchk(`MTSEQ_OFF_SRC, 32'h0, "src forced");
      rdchk(`MTSEQ_OFF_SAMPLES, 32'h1, "samples one");
      rdchk(`MTSEQ_OFF_TRIGS, 32'h1, "trigs one");
      apb(1'b0, `MTSEQ_OFF_CTRL, 32'h0);
      check(rd & 32'h4, 32'h4, "delay auto");
      check(starts - base, i - 1, "measure starts");
    end
    $display("test configure done");
    apb(1'b1, `MTSEQ_OFF_TRIGS, 32'h3);
    apb(1'b1, `MTSEQ_OFF_CTRL, 32'h6);
    wait_armed;
    base = starts;
    @(posedge clk) single_key <= 1'b1;
    @(posedge clk) single_key <= 1'b0;
    wait_armed;
    check(starts - base, 1, "key burst");
    ext_pulse;
    wait_armed;
    check(starts - base, 2, "local ext");
    apb(1'b0, `MTSEQ_OFF_STATUS, 32'h0);
    check(32'(rd[2:0]), 32'h3, "stays armed");
    apb(1'b1, `MTSEQ_OFF_CTRL, 32'h5);
    rdchk(`MTSEQ_OFF_TRIGS, 32'h3, "trigs restored");
    apb(1'b1, `MTSEQ_OFF_SAMPLES, 32'h5);
    apb(1'b1, `MTSEQ_OFF_CMD, 32'h20);
    rdchk(`MTSEQ_OFF_SRC, 32'h0, "src iface reset");
    rdchk(`MTSEQ_OFF_SAMPLES, 32'h1, "samples iface reset");
    apb(1'b0, `MTSEQ_OFF_CTRL, 32'h0);
    check(rd & 32'h1, 32'h1, "remote kept");
    $display("test local done");
    end_of_test;
  end
  initial begin
    #4000000;
    miscompares++;
    end_of_test;
  end
endmodule // tb_measurement_trigger_sequencer
bind mtseq_top mtseq_properties u_props (.clk(clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .reading_done(reading_done), .reading_start(reading_start), .sample_active(sample_active),
  .trig_waiting(trig_waiting), .measurement_complete_output(measurement_complete_output));
